// file: src/psc_params.svh
// Constants for the system-control register bank: register indices,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PSC_IDX_ID 16'h0000
`define PSC_IDX_BTN 16'h4005
`define PSC_IDX_RST 16'h4006
`define PSC_IDX_CIF 16'h4007
`define PSC_IDX_KEY 16'h4008
`define PSC_IDX_SCR 16'h4009
`define PSC_IDX_FUSE 16'h400A
`define PSC_IDX_PIN 16'h400C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PSC_BTN_SEC 9:8
`define PSC_BTN_PRIM 5:4
`define PSC_BTN_STS 3
`define PSC_BTN_TO 1:0
`define PSC_RST_RELOAD 15
`define PSC_RST_ADRV 13
`define PSC_RST_BATT 12
`define PSC_RST_SCOPE 10
`define PSC_RST_AUX 6
`define PSC_RST_MASK 5
`define PSC_RST_DRIVE 4
`define PSC_RESET_RELEASE_DELAY 1:0
`define PSC_CIF_AUTO 2
`define PSC_FUSE_PROG 15
`define PSC_FUSE_MEM 13
`define PSC_FUSE_FINAL 11
`define PSC_FUSE_VERIFY 10
`define PSC_FUSE_WRITE 9
`define PSC_FUSE_READ 8
`define PSC_FUSE_MARGIN 7:6
`define PSC_FUSE_BULK 5
`define PSC_FUSE_PAGE 1:0
`define PSC_PIN_LSB 7

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define PSC_KEY_UNLOCK 16'h9716
`define PSC_RV_SEC 2'h1
`define PSC_RV_PRIM 2'h0
`define PSC_RV_TO 2'h0
`define PSC_RV_DUR 2'h3
`define PSC_ACT_INT 2'h0
`define PSC_ACT_ON 2'h1
`define PSC_ACT_OFF 2'h2
`define PSC_FN_GPIO 4'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PSC_CLK_HZ 200000000
`define PSC_MS_PER_S 1000
`define PSC_BTN_BASE_S 1
`define PSC_DUR0_MS 3
`define PSC_DUR1_MS 11
`define PSC_DUR2_MS 51
`define PSC_DUR3_MS 101

`endif

// file: src/psc_pkg.sv
// Types shared by the system-control register bank.
// Assumes the constant header is on the include path.
`include "psc_params.svh"

package psc_pkg;

  typedef enum logic [1:0] {
    BTN_IDLE,
    BTN_HOLD,
    BTN_DONE
  } psc_btn_state_t;

  typedef logic [15:0] psc_word_t;

endpackage : psc_pkg

// file: src/psc_regs.sv
// System-control register bank of the power-management device, APB slave.
// Assumes the main power state machine, GPIO setup and the fuse memory
// sit outside and exchange levels and one-cycle pulses with this bank.
`timescale 1ns/1ps
`default_nettype none
`include "psc_params.svh"

// How it works
// - Held button past timeout fires secondary action
// - Button press applies the primary action
// - Every button press raises an interrupt
// - Status bit mirrors the live button pin
// - Timeout field selects 1, 2, 4, 8 s
// - Protected writes need key 9716h present
// - Reload config on scheduled ON when enabled
// - Gate bit drives switch pin, cleared at OFF
// - Soft reset restores defaults unless scope set
// - Any write to index zero soft-resets
// - Aux reset in sleep follows its bit
// - Mask bit hides external reset in sleep
// - Reset pin in sleep follows drive bit
// - Reset released after selected delay, 3-101 ms
// - Auto-advance bit steers interface addressing
// - Scratch word survives soft reset and backup
// - Program-state select latches until device reset
// - Memory select routes commands, fuse by default
// - Command bits launch finalise/verify/write/read pulses
// - Margin level accompanies read and verify
// - Bulk bit selects one or all pages
// - Page field picks the single page
// - Pin level bits read input, drive output
module psc_regs #(
  parameter int ADDR_W = 18,
  parameter int NPINS = 5,
  parameter logic [15:0] CHIP_ID = 16'h5A3C,            // Arbitrary value
  parameter int unsigned BTN_UNIT_CYCLES = `PSC_BTN_BASE_S * `PSC_CLK_HZ,
  parameter int unsigned MS_CYCLES = `PSC_CLK_HZ / `PSC_MS_PER_S
) (
  input wire logic sys_clk,                  // 200 MHz clock
  input wire logic reset,                    // Synchronous, active high
  input wire logic psel,                     // APB select
  input wire logic penable,                  // APB access phase
  input wire logic pwrite,                   // APB direction
  input wire logic [ADDR_W-1:0] paddr,       // APB byte address
  input wire logic [31:0] pwdata,            // APB write data
  output logic [31:0] prdata,                // APB read data
  output logic pready,                       // APB ready
  output logic pslverr,                      // APB error, unmapped address
  input wire logic button_pin_n,             // Power button, low = pressed
  output logic button_irq,                   // Interrupt request pulse
  output logic on_request,                   // ON request pulse
  output logic off_request,                  // OFF request pulse
  input wire logic in_sleep,                 // Power state is SLEEP
  input wire logic off_entry,                // Pulse on entering OFF
  input wire logic on_scheduled,             // Pulse when ON is scheduled
  input wire logic seq_done,                 // Pulse at end of ON/WAKE sequence
  output logic reload_config,                // Bootstrap reload pulse
  output logic battery_switch_gate_pin_n,    // Battery switch gate, low = on
  output logic adaptor_switch_drive_strength, // Adaptor switch strong drive
  input wire logic ext_reset_n,              // External reset input
  output logic ext_reset_active,             // External reset after mask
  output logic reset_out_n,                  // Reset output pin, low = asserted
  output logic aux_reset_out,                // Auxiliary reset GPIO function
  output logic soft_reset_pulse,             // Software reset event
  output logic address_auto_advance,         // Control interface auto-increment
  output logic program_mode,                 // PROGRAM state selected
  output logic config_shadow_memory,         // Commands target shadow memory
  output logic cmd_finalise,                 // Finalise command pulse
  output logic cmd_verify,                   // Verify command pulse
  output logic cmd_write,                    // Write command pulse
  output logic cmd_read,                     // Read command pulse
  output logic [1:0] margin_level,           // Margin for read and verify
  output logic all_pages_select,             // Act on all pages
  output logic [2:0] page_number,            // Decoded single page
  output logic page_reserved,                // Reserved page code selected
  input wire logic [4*NPINS-1:0] pin_function, // Pin function codes, four bits per pin
  input wire logic [NPINS-1:0] pin_direction,  // Pin direction, 0 = output
  input wire logic [NPINS-1:0] pin_polarity,   // Pin polarity, 0 = inverted
  input wire logic [NPINS-1:0] pin_in,         // Pin input level
  output logic [NPINS-1:0] pin_out,            // Pin output level
  output logic [NPINS-1:0] pin_oe              // Pin output enable
);

  // Elaboration stops on values the fixed decode cannot serve
  if (ADDR_W != 18 || NPINS != 5 || BTN_UNIT_CYCLES < 1 || MS_CYCLES < 1 ||
      BTN_UNIT_CYCLES > 32'd268435455) begin : g_param_check
    $error("psc_regs: unsupported parameter values");
  end


  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic [15:0] idx;
  logic aligned;
  logic hit;
  logic wr_en;
  logic [15:0] wd;
  logic unlocked;
  logic soft_clr;

  assign idx = paddr[17:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit = aligned && (idx == `PSC_IDX_ID || idx == `PSC_IDX_BTN || idx == `PSC_IDX_RST ||
                idx == `PSC_IDX_CIF || idx == `PSC_IDX_KEY || idx == `PSC_IDX_SCR ||
                idx == `PSC_IDX_FUSE || idx == `PSC_IDX_PIN);
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_en = psel && penable && pwrite && hit;
  assign wd = pwdata[15:0];

  // Registers backing the fields
  logic [15:0] key_q;
  logic [1:0] sec_q, prim_q, to_q, dur_q, margin_q, page_q;
  logic reload_q, adrv_q, batt_q, scope_q, aux_q, mask_q, drive_q;
  logic auto_q, scratch_en;
  logic [15:0] scratch_q;
  logic prog_q, mem_q, bulk_q, final_done_q;
  logic [NPINS-1:0] lvl_q;

  assign unlocked = (key_q == `PSC_KEY_UNLOCK);
  // Scope bit clear means the map returns to defaults on a soft reset
  assign soft_clr = wr_en && idx == `PSC_IDX_ID && !scope_q;

  // ----------------------------------------------------------------------
  // Key and scratch
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || soft_clr) begin
      key_q <= 16'h0000;
    end else if (wr_en && idx == `PSC_IDX_KEY) begin
      key_q <= wd;
    end
  end

  // Scratch is left alone by a soft reset, as it lives in backup
  assign scratch_en = wr_en && idx == `PSC_IDX_SCR;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scratch_q <= 16'h0000;
    end else if (scratch_en) begin
      scratch_q <= wd;
    end
  end

  // ----------------------------------------------------------------------
  // Button control and reset control fields
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || soft_clr) begin
      sec_q <= `PSC_RV_SEC;
      prim_q <= `PSC_RV_PRIM;
      to_q <= `PSC_RV_TO;
    end else if (wr_en && idx == `PSC_IDX_BTN && unlocked) begin
      sec_q <= wd[`PSC_BTN_SEC];
      prim_q <= wd[`PSC_BTN_PRIM];
      to_q <= wd[`PSC_BTN_TO];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || soft_clr) begin
      reload_q <= 1'b1;
      scope_q <= 1'b1;
      aux_q <= 1'b1;
      mask_q <= 1'b1;
      drive_q <= 1'b1;
      dur_q <= `PSC_RV_DUR;
    end else if (wr_en && idx == `PSC_IDX_RST && unlocked) begin
      reload_q <= wd[`PSC_RST_RELOAD];
      scope_q <= wd[`PSC_RST_SCOPE];
      aux_q <= wd[`PSC_RST_AUX];
      mask_q <= wd[`PSC_RST_MASK];
      drive_q <= wd[`PSC_RST_DRIVE];
      dur_q <= wd[`PSC_RESET_RELEASE_DELAY];
    end
  end

  // Unprotected bits of the reset control register; entering OFF wins
  // over a write in the same cycle so the switch is never left enabled.
  always_ff @(posedge sys_clk) begin
    if (reset || soft_clr || off_entry) begin
      batt_q <= 1'b0;
    end else if (wr_en && idx == `PSC_IDX_RST) begin
      batt_q <= wd[`PSC_RST_BATT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || soft_clr) begin
      adrv_q <= 1'b0;
      auto_q <= 1'b1;
    end else if (wr_en) begin
      if (idx == `PSC_IDX_RST) begin
        adrv_q <= wd[`PSC_RST_ADRV];
      end
      if (idx == `PSC_IDX_CIF) begin
        auto_q <= wd[`PSC_CIF_AUTO];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fuse memory control
  // ----------------------------------------------------------------------
  logic fuse_wr;
  assign fuse_wr = wr_en && idx == `PSC_IDX_FUSE;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prog_q <= 1'b0;
    end else if (fuse_wr && unlocked && wd[`PSC_FUSE_PROG]) begin
      prog_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || soft_clr) begin
      mem_q <= 1'b1;
      margin_q <= 2'h0;
    end else if (fuse_wr && unlocked) begin
      mem_q <= wd[`PSC_FUSE_MEM];
      margin_q <= wd[`PSC_FUSE_MARGIN];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || soft_clr) begin
      bulk_q <= 1'b0;
      page_q <= 2'h0;
    end else if (fuse_wr) begin
      bulk_q <= wd[`PSC_FUSE_BULK];
      page_q <= wd[`PSC_FUSE_PAGE];
    end
  end

  // Command bits are write-one pulses and read back as zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmd_finalise <= 1'b0;
      cmd_verify <= 1'b0;
      cmd_write <= 1'b0;
      cmd_read <= 1'b0;
    end else begin
      cmd_finalise <= fuse_wr && unlocked && wd[`PSC_FUSE_FINAL];
      cmd_verify <= fuse_wr && unlocked && wd[`PSC_FUSE_VERIFY];
      cmd_write <= fuse_wr && unlocked && wd[`PSC_FUSE_WRITE] && !final_done_q;
      cmd_read <= fuse_wr && unlocked && wd[`PSC_FUSE_READ];
    end
  end

  // After finalise no further write command leaves the bank
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      final_done_q <= 1'b0;
    end else if (cmd_finalise) begin
      final_done_q <= 1'b1;
    end
  end

  always_comb begin
    page_reserved = 1'b0;
    if (mem_q) begin
      page_number = {1'b0, page_q};
    end else begin
      page_number = 3'(page_q) + 3'h2;
      page_reserved = (page_q == 2'h3);
    end
  end

  // ----------------------------------------------------------------------
  // Pin level bits
  // ----------------------------------------------------------------------
  logic [NPINS-1:0] lvl_rd;
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (reset || soft_clr) begin
          lvl_q[gi] <= 1'b0;
        end else if (wr_en && idx == `PSC_IDX_PIN) begin
          lvl_q[gi] <= wd[`PSC_PIN_LSB + gi];
        end
      end
      // Polarity 0 stores the opposite of the pin level
      assign pin_out[gi] = pin_polarity[gi] ? lvl_q[gi] : !lvl_q[gi];
      assign pin_oe[gi] = (pin_function[4*gi +: 4] == `PSC_FN_GPIO) && !pin_direction[gi];
      assign lvl_rd[gi] = pin_polarity[gi] ? pin_in[gi] : !pin_in[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Power button
  // ----------------------------------------------------------------------
  psc_pkg::psc_btn_state_t btn_q;
  logic [31:0] hold_cnt_q;
  logic [31:0] hold_lim;
  logic pressed, press_edge, hold_done;

  assign pressed = !button_pin_n;
  assign hold_lim = BTN_UNIT_CYCLES << to_q;
  assign press_edge = pressed && btn_q == psc_pkg::BTN_IDLE;
  assign hold_done = btn_q == psc_pkg::BTN_HOLD && hold_cnt_q == hold_lim - 32'd1;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      btn_q <= psc_pkg::BTN_IDLE;
      hold_cnt_q <= 32'd0;
    end else begin
      case (btn_q)
        psc_pkg::BTN_IDLE: begin
          hold_cnt_q <= 32'd0;
          if (pressed) begin
            btn_q <= psc_pkg::BTN_HOLD;
          end
        end
        psc_pkg::BTN_HOLD: begin
          hold_cnt_q <= hold_cnt_q + 32'd1;
          if (!pressed) begin
            btn_q <= psc_pkg::BTN_IDLE;
          end else if (hold_done) begin
            btn_q <= psc_pkg::BTN_DONE;
          end
        end
        psc_pkg::BTN_DONE: begin
          if (!pressed) begin
            btn_q <= psc_pkg::BTN_IDLE;
          end
        end
        default: btn_q <= psc_pkg::BTN_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      button_irq <= 1'b0;
      on_request <= 1'b0;
      off_request <= 1'b0;
    end else begin
      button_irq <= press_edge || (hold_done && pressed && sec_q == `PSC_ACT_INT);
      on_request <= (press_edge && prim_q == `PSC_ACT_ON) ||
                    (hold_done && pressed && sec_q == `PSC_ACT_ON);
      off_request <= (press_edge && prim_q == `PSC_ACT_OFF) ||
                     (hold_done && pressed && sec_q == `PSC_ACT_OFF);
    end
  end

  // ----------------------------------------------------------------------
  // Reset output and release delay
  // ----------------------------------------------------------------------
  logic [31:0] rel_cnt_q;
  logic [31:0] rel_lim;

  always_comb begin
    case (dur_q)
      2'h0: rel_lim = `PSC_DUR0_MS * MS_CYCLES;
      2'h1: rel_lim = `PSC_DUR1_MS * MS_CYCLES;
      2'h2: rel_lim = `PSC_DUR2_MS * MS_CYCLES;
      default: rel_lim = `PSC_DUR3_MS * MS_CYCLES;
    endcase
  end

  // Counter loads at the end of the sequence and holds reset until empty
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rel_cnt_q <= 32'd0;
    end else if (seq_done) begin
      rel_cnt_q <= rel_lim;
    end else if (rel_cnt_q != 32'd0) begin
      rel_cnt_q <= rel_cnt_q - 32'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reset_out_n <= 1'b0;
      aux_reset_out <= 1'b1;
      reload_config <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      if (in_sleep) begin
        reset_out_n <= !drive_q;
        aux_reset_out <= aux_q;
      end else begin
        reset_out_n <= !(seq_done || rel_cnt_q > 32'd1);
        aux_reset_out <= seq_done || rel_cnt_q > 32'd1;
      end
      reload_config <= on_scheduled && reload_q;
      soft_reset_pulse <= wr_en && idx == `PSC_IDX_ID;
    end
  end

  assign ext_reset_active = !ext_reset_n && !(in_sleep && mask_q);
  assign battery_switch_gate_pin_n = !batt_q;
  assign adaptor_switch_drive_strength = adrv_q;
  assign address_auto_advance = auto_q;
  assign program_mode = prog_q;
  assign config_shadow_memory = !mem_q;
  assign margin_level = margin_q;
  assign all_pages_select = bulk_q;

  // ----------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  logic [15:0] rd_d;
  always_comb begin
    rd_d = 16'h0000;
    case (idx)
      `PSC_IDX_ID: rd_d = CHIP_ID;
      `PSC_IDX_BTN: begin
        rd_d[`PSC_BTN_SEC] = sec_q;
        rd_d[`PSC_BTN_PRIM] = prim_q;
        rd_d[`PSC_BTN_STS] = button_pin_n;
        rd_d[`PSC_BTN_TO] = to_q;
      end
      `PSC_IDX_RST: begin
        rd_d[`PSC_RST_RELOAD] = reload_q;
        rd_d[`PSC_RST_ADRV] = adrv_q;
        rd_d[`PSC_RST_BATT] = batt_q;
        rd_d[`PSC_RST_SCOPE] = scope_q;
        rd_d[`PSC_RST_AUX] = aux_q;
        rd_d[`PSC_RST_MASK] = mask_q;
        rd_d[`PSC_RST_DRIVE] = drive_q;
        rd_d[`PSC_RESET_RELEASE_DELAY] = dur_q;
      end
      `PSC_IDX_CIF: rd_d[`PSC_CIF_AUTO] = auto_q;
      `PSC_IDX_KEY: rd_d = key_q;
      `PSC_IDX_SCR: rd_d = scratch_q;
      `PSC_IDX_FUSE: begin
        rd_d[`PSC_FUSE_PROG] = prog_q;
        rd_d[`PSC_FUSE_MEM] = mem_q;
        rd_d[`PSC_FUSE_MARGIN] = margin_q;
        rd_d[`PSC_FUSE_BULK] = bulk_q;
        rd_d[`PSC_FUSE_PAGE] = page_q;
      end
      `PSC_IDX_PIN: rd_d[`PSC_PIN_LSB +: NPINS] = lvl_rd;
      default: rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= (hit && !pwrite) ? {16'h0000, rd_d} : 32'h0000_0000;
    end
  end

endmodule : psc_regs
`default_nettype wire

// file: tb/pmic_system_control_regs_test.sv
// Testbench for the system-control register bank: host model and scenarios.
// Assumes button and millisecond counts shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
`include "psc_params.svh"
module pmic_system_control_regs_test;
  localparam int UNIT = 64;
  localparam int MS = 8;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, hang, aux_reset_out, ext_reset_active;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic button_pin_n, button_irq, on_request, off_request, in_sleep, reload_config, ext_reset_n, reset_out_n;
  logic battery_switch_gate_pin_n, address_auto_advance, program_mode, config_shadow_memory;
  logic [2:0] page_number, ev;
  logic [19:0] pin_function;
  logic [4:0] pin_direction, pin_polarity, pin_in, pin_out;
  logic [15:0] rv;
  int fails, cmp_count, n;
  wire off_entry = ev[0];
  wire on_scheduled = ev[1];
  wire seq_done = ev[2];
  wire [4:0] obs = {reset_out_n, off_request, on_request, button_irq, reload_config};
  psc_regs #(.BTN_UNIT_CYCLES(UNIT), .MS_CYCLES(MS)) dut (.*, .adaptor_switch_drive_strength(), .soft_reset_pulse(),
    .cmd_finalise(), .cmd_verify(), .cmd_write(), .cmd_read(), .margin_level(), .all_pages_select(),
    .page_reserved(), .pin_oe());
  psc_host_model host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict;
    if (hang === 1'b1) fails++;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    host.xfer(1'b1, idx, d, rv);
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
    host.xfer(1'b0, idx, 16'h0, rv);
    chk(rv, exp);
  endtask : rd
  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    @(posedge sys_clk);
    ev[i] <= 1'b0;
  endtask : pulse
  // Bounded wait on one observed output; a lapse ends the run
  task automatic wait_hi(input int i, input int lim);
    n = 0;
    while (obs[i] !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (obs[i] !== 1'b1) begin
      fails++;
      $display("Error at %0t: wait expired", $time);
      print_verdict();
    end
  endtask : wait_hi
  task automatic t_lock;
    rd(`PSC_IDX_BTN, 16'h0108);
    rd(`PSC_IDX_CIF, 16'h0004);
    rd(`PSC_IDX_FUSE, 16'h2000);
    chk(16'(address_auto_advance), 16'h1);
    host.xfer(1'b0, 16'h0001, 16'h0, rv);
    chk(16'(host.err), 16'h1);
    wr(`PSC_IDX_RST, 16'h0000);
    rd(`PSC_IDX_RST, 16'h8473);
    wr(`PSC_IDX_KEY, `PSC_KEY_UNLOCK);
    wr(`PSC_IDX_RST, 16'h9070);
    rd(`PSC_IDX_RST, 16'h9070);
    chk(16'(battery_switch_gate_pin_n), 16'h0);
    pulse(0);
    rd(`PSC_IDX_RST, 16'h8070);
    pulse(1);
    wait_hi(0, 4);
    pulse(2);
    repeat (2) @(posedge sys_clk);
    chk(16'(reset_out_n), 16'h0);
    wait_hi(4, 40);
    chk(16'(n >= 3 * MS - 4 && n <= 3 * MS + 2), 16'h1);
    $display("Lock test done");
  endtask : t_lock
  task automatic t_button;
    wr(`PSC_IDX_BTN, 16'h0210);
    button_pin_n <= 1'b0;
    wait_hi(2, 4);
    chk(16'(button_irq), 16'h1);
    rd(`PSC_IDX_BTN, 16'h0210);
    wait_hi(3, UNIT + 16);
    chk(16'(n >= UNIT - 16), 16'h1);
    button_pin_n <= 1'b1;
    wr(`PSC_IDX_BTN, 16'h0003);
    button_pin_n <= 1'b0;
    wait_hi(1, 4);
    @(posedge sys_clk);
    wait_hi(1, 8 * UNIT + 16);
    chk(16'(n >= 8 * UNIT - 8), 16'h1);
    button_pin_n <= 1'b1;
    $display("Button test done");
  endtask : t_button
  task automatic t_soft;
    wr(`PSC_IDX_FUSE, 16'h8102);
    wr(`PSC_IDX_SCR, 16'h1234);
    chk(16'(page_number), 16'h0004);
    chk(16'(config_shadow_memory), 16'h1);
    wr(`PSC_IDX_ID, 16'h0000);
    rd(`PSC_IDX_RST, 16'h8473);
    rd(`PSC_IDX_KEY, 16'h0000);
    rd(`PSC_IDX_SCR, 16'h1234);
    chk(16'(program_mode), 16'h1);
    in_sleep <= 1'b1;
    ext_reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({13'h0, reset_out_n, aux_reset_out, ext_reset_active}, 16'h0002);
    in_sleep <= 1'b0;
    ext_reset_n <= 1'b1;
    pin_polarity <= 5'h1F;
    pin_in <= 5'h10;
    wr(`PSC_IDX_PIN, 16'h0800);
    @(posedge sys_clk);
    chk(16'(pin_out[4]), 16'h1);
    rd(`PSC_IDX_PIN, 16'h0800);
    pin_polarity <= 5'h00;
    rd(`PSC_IDX_PIN, 16'h0780);
    chk(16'(pin_out[4]), 16'h0);
    $display("Soft test done");
  endtask : t_soft
  initial begin
    fails = 0;
    cmp_count = 0;
    {reset, button_pin_n, ext_reset_n} = 3'h7;
    {in_sleep, ev, pin_function, pin_direction, pin_polarity, pin_in} = '0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    t_lock();
    t_button();
    t_soft();
    print_verdict();
  end
  initial begin
    for (int i = 0; i < 100000 && hang !== 1'b1; i++) @(posedge sys_clk);
    fails++;
    print_verdict();
  end
endmodule : pmic_system_control_regs_test
`default_nettype wire

// file: tb/psc_host_model.sv
// Host model: APB master that issues one whole transfer per call.
// Assumes a slave that samples on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
  input wire logic sys_clk, // Bus clock
  input wire logic pready, // Slave ready
  input wire logic pslverr, // Slave error
  input wire logic [31:0] prdata, // Read data
  output logic psel, // Select
  output logic penable, // Access phase
  output logic pwrite, // Direction
  output logic [17:0] paddr, // Byte address
  output logic [31:0] pwdata, // Write data
  output logic hang // Ready never came
);
  logic err;
  initial begin
    {psel, penable, pwrite, paddr, pwdata, hang, err} = '0;
  end
  // --------
  // Transfer
  // --------
  // Request held until ready is seen or 16 cycles pass
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [15:0] wd, output logic [15:0] rd);
    int k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {16'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) hang <= 1'b1;
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : psc_host_model
`default_nettype wire

// file: tb/psc_regs_monitor.sv
// Checker for the system-control register bank, bound to its ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module psc_regs_monitor #(
  parameter int ADDR_W = 18,
  parameter int NPINS = 5
) (
  input wire logic sys_clk, reset, // Clock and reset
  input wire logic psel, penable, pwrite, // APB control
  input wire logic [ADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic button_pin_n, button_irq, // Button
  input wire logic on_scheduled, reload_config, // Reload path
  input wire logic off_entry, battery_switch_gate_pin_n, // Gate path
  input wire logic seq_done, in_sleep, reset_out_n, // Release path
  input wire logic ext_reset_n, ext_reset_active, // External reset
  input wire logic soft_reset_pulse, cmd_read, program_mode, // Events
  input wire logic config_shadow_memory, page_reserved, // Memory routing
  input wire logic [2:0] page_number, // Decoded page
  input wire logic [4*NPINS-1:0] pin_function, // Pin functions
  input wire logic [NPINS-1:0] pin_direction, pin_oe // Pin setup
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // --------
  // Properties
  // --------
  a_press_irq: assert property ($fell(button_pin_n) |-> ##[1:2] button_irq)
    else $error("button press raised no interrupt");
  a_irq_single: assert property (button_irq |=> !button_irq)
    else $error("interrupt pulse longer than one cycle");
  a_gate_off: assert property (off_entry |=> battery_switch_gate_pin_n)
    else $error("gate not released on OFF entry");
  a_reload_cause: assert property (reload_config |-> $past(on_scheduled))
    else $error("reload without a scheduled ON");
  a_soft_write: assert property (psel && penable && pwrite && paddr == '0 |=> soft_reset_pulse)
    else $error("write to index zero gave no soft reset");
  a_release_hold: assert property (seq_done && !in_sleep |=> !reset_out_n [*8])
    else $error("reset output released too early");
  a_mask_awake: assert property (!in_sleep |-> ext_reset_active == !ext_reset_n)
    else $error("external reset lost outside sleep");
  a_cmd_cause: assert property (cmd_read |-> $past(psel && penable && pwrite && pwdata[8]))
    else $error("read command without a write of its bit");
  a_prog_sticky: assert property (program_mode |=> program_mode)
    else $error("program mode left before reset");
  a_pin_enable: assert property (pin_oe[NPINS-1] == (pin_function[4*NPINS-1 -: 4] == 4'h0 && !pin_direction[NPINS-1]))
    else $error("pin output enable wrong");
  a_shadow_page: assert property (config_shadow_memory && !page_reserved |-> page_number >= 3'h2)
    else $error("shadow page below two");
  c_irq: cover property (button_irq);
  c_release: cover property ($rose(reset_out_n));
  c_soft: cover property (soft_reset_pulse);
endmodule : psc_regs_monitor
bind psc_regs psc_regs_monitor #(.ADDR_W(ADDR_W), .NPINS(NPINS)) u_monitor (.*);
`default_nettype wire
